// >>> verilog/stn_pkg.sv
package stn_pkg;

	// ------------------------------------------------------------
	// clocks and timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_PERIOD_PS = 5000;
	localparam int PWR_STEP_TIME_US = 10;
	localparam int PWR_STEP_CYC = (PWR_STEP_TIME_US * 1000000 + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// field widths and positions
	// ------------------------------------------------------------
	localparam int HTOT_W = 8;
	localparam int HACT_W = 6;
	localparam int V_W = 9;
	localparam int H_CNT_W = 9;
	localparam int LOAD_POS_W = 8;
	localparam int DATA_W = 8;
	localparam int MONO_DATA_W = 4;
	localparam int PAL_DEPTH = 256;
	localparam int PAL_W = 18;
	localparam int HVIS_SHIFT = 3;
	localparam int HTOT_SHIFT = 1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		STN_D1 = 2'h0,
		STN_D2 = 2'h1,
		STN_D4 = 2'h2,
		STN_D8 = 2'h3
	} stn_depth_t;

	typedef enum logic [1:0] {
		STN_PWR_OFF = 2'h0,
		STN_PWR_LOGIC = 2'h1,
		STN_PWR_ON = 2'h3,
		STN_PWR_DOWN = 2'h2
	} stn_pwr_state_t;

	typedef struct packed {
		logic [HTOT_W-1:0] htot;
		logic [HACT_W-1:0] hact;
		logic [V_W-1:0] vtot;
		logic [V_W-1:0] vact;
		logic [LOAD_POS_W-1:0] load_start_pos;
		logic [LOAD_POS_W-1:0] load_end_pos;
		logic load_clock_polarity;
		logic blank_row_load_enable;
		logic color;
		stn_depth_t depth;
	} stn_cfg_t;

	typedef struct packed {
		logic panel_shift_clock;
		logic line_load_clock;
		logic panel_logic_power_out;
		logic panel_bias_power_out;
	} stn_pins_t;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam stn_cfg_t CFG_RST = '0;
	localparam logic LOAD_IDLE_RST = 1'b0;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [H_CNT_W-1:0] stn_x2(input logic [HTOT_W-1:0] f);
		return {f, HTOT_SHIFT'(0)};
	endfunction : stn_x2

	function automatic logic [H_CNT_W-1:0] stn_x8(input logic [HACT_W-1:0] f);
		return {f, HVIS_SHIFT'(0)};
	endfunction : stn_x8

endpackage : stn_pkg

// >>> verilog/stn_sync2.sv
`timescale 1ns/1ps
module stn_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// level in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : stn_sync2

// >>> verilog/stn_power_seq.sv
`timescale 1ns/1ps
module stn_power_seq #(
	parameter int STEP_CYC = stn_pkg::PWR_STEP_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// request and supplies
	input wire logic panel_enable,
	output logic logic_on,
	output logic bias_on,
	output logic up_done
);
	import stn_pkg::*;

	localparam int CW = $clog2(STEP_CYC + 1);

	stn_pwr_state_t state_reg;
	logic [CW-1:0] cnt_reg;
	logic step_done;

	assign step_done = (cnt_reg == CW'(STEP_CYC));

	// ------------------------------------------------------------
	// logic supply first, bias last; reverse on the way down
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= STN_PWR_OFF;
		end else begin
			case (state_reg)
				STN_PWR_OFF: if (panel_enable) state_reg <= STN_PWR_LOGIC;
				STN_PWR_LOGIC: begin
					if (!panel_enable) state_reg <= STN_PWR_OFF;
					else if (step_done) state_reg <= STN_PWR_ON;
				end
				STN_PWR_ON: if (!panel_enable) state_reg <= STN_PWR_DOWN;
				STN_PWR_DOWN: if (step_done) state_reg <= STN_PWR_OFF;
				default: state_reg <= STN_PWR_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (state_reg == STN_PWR_LOGIC || state_reg == STN_PWR_DOWN) begin
			if (!step_done) cnt_reg <= cnt_reg + CW'(1);
		end else begin
			cnt_reg <= '0;
		end
	end

	assign logic_on = (state_reg != STN_PWR_OFF);
	assign bias_on = (state_reg == STN_PWR_ON);
	assign up_done = bias_on;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_bias_needs_logic;
		@(posedge core_clk) disable iff (!nrst) $fell(logic_on) |-> !$past(bias_on);
	endproperty
	a_bias_needs_logic: assert property (p_bias_needs_logic) else $error("logic supply dropped with bias on");

	property p_bias_after_step;
		@(posedge core_clk) disable iff (!nrst) $rose(bias_on) |-> $past(cnt_reg) == CW'(STEP_CYC);
	endproperty
	a_bias_after_step: assert property (p_bias_after_step) else $error("bias rose before delay");

	c_power_up: cover property (@(posedge core_clk) disable iff (!nrst) $rose(bias_on));
endmodule : stn_power_seq

// >>> verilog/stn_lcd_timing.sv
`timescale 1ns/1ps
module stn_lcd_timing #(
	parameter int PWR_STEP_CYC = stn_pkg::PWR_STEP_CYC,
	parameter int PAL_DEPTH = stn_pkg::PAL_DEPTH
) (
	// system side
	input wire logic core_clk,
	input wire logic nrst,
	// pixel-rate link clock
	input wire logic pix_clk,
	// configuration and control
	input wire stn_pkg::stn_cfg_t cfg_in,
	input wire logic panel_enable,
	input wire logic panel_pin_mode_select,
	output logic cfg_busy,
	output logic panel_powered,
	// color table write port
	input wire logic pal_we,
	input wire logic [7:0] pal_idx,
	input wire logic [stn_pkg::PAL_W-1:0] pal_wdata,
	// pixels from the graphics memory port, pixel clock domain
	input wire logic [stn_pkg::DATA_W-1:0] pix_in,
	output logic pix_take,
	// external controller signals used in pin mode
	input wire logic ext_ctrl_chip_select_n,
	input wire logic wide_mem_select_n,
	input wire logic gp_power_out_1,
	input wire logic gp_power_out_0,
	// panel pins
	output stn_pkg::stn_pins_t pins,
	output logic [stn_pkg::DATA_W-1:0] panel_data,
	output logic panel_data_upper_en,
	output logic [stn_pkg::PAL_W-1:0] color_rgb,
	output logic frame_start
);
	import stn_pkg::*;

	// ------------------------------------------------------------
	// system-side configuration hold and request toggle
	// ------------------------------------------------------------
	stn_cfg_t cfg_hold_reg;
	logic req_tgl_reg;
	logic ack_core;
	logic logic_on;
	logic bias_on;
	logic up_done;

	assign cfg_busy = (req_tgl_reg != ack_core);

	// hold stays still until the pixel side has taken it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_hold_reg <= CFG_RST;
			req_tgl_reg <= 1'b0;
		end else if (!cfg_busy && cfg_in != cfg_hold_reg) begin
			cfg_hold_reg <= cfg_in;
			req_tgl_reg <= ~req_tgl_reg;
		end
	end

	// ------------------------------------------------------------
	// color table
	// ------------------------------------------------------------
	logic [PAL_W-1:0] pal_mem [PAL_DEPTH];

	always_ff @(posedge core_clk) begin
		if (pal_we) pal_mem[pal_idx] <= pal_wdata;
	end

	// ------------------------------------------------------------
	// panel power sequencing
	// ------------------------------------------------------------
	stn_power_seq #(.STEP_CYC(PWR_STEP_CYC)) u_pwr (
		.core_clk(core_clk),
		.nrst(nrst),
		.panel_enable(panel_enable && !panel_pin_mode_select),
		.logic_on(logic_on),
		.bias_on(bias_on),
		.up_done(up_done)
	);
	assign panel_powered = up_done;

	// ------------------------------------------------------------
	// pixel clock reset and crossings
	// ------------------------------------------------------------
	logic rst_meta_reg;
	logic pix_rst_n;
	logic scan_pix;
	logic req_pix;
	logic ack_tgl_reg;

	always_ff @(posedge pix_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			pix_rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			pix_rst_n <= rst_meta_reg;
		end
	end

	stn_sync2 #(.W(1)) u_sync_scan (
		.clk(pix_clk),
		.rst_n(pix_rst_n),
		.d(up_done),
		.q(scan_pix)
	);

	stn_sync2 #(.W(1)) u_sync_req (
		.clk(pix_clk),
		.rst_n(pix_rst_n),
		.d(req_tgl_reg),
		.q(req_pix)
	);

	stn_sync2 #(.W(1)) u_sync_ack (
		.clk(core_clk),
		.rst_n(nrst),
		.d(ack_tgl_reg),
		.q(ack_core)
	);

	// ------------------------------------------------------------
	// shadow settings, swapped only at frame top or while idle
	// ------------------------------------------------------------
	stn_cfg_t cfg_pix;
	logic [H_CNT_W-1:0] h_cnt_reg;
	logic [V_W-1:0] v_cnt_reg;
	logic at_top;
	assign at_top = (h_cnt_reg == '0) && (v_cnt_reg == '0);

	// swapping mid-frame would tear the row timing
	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			cfg_pix <= CFG_RST;
			ack_tgl_reg <= 1'b0;
		end else if (req_pix != ack_tgl_reg && (at_top || !scan_pix)) begin
			cfg_pix <= cfg_hold_reg;
			ack_tgl_reg <= req_pix;
		end
	end

	// ------------------------------------------------------------
	// position counters
	// ------------------------------------------------------------
	logic [H_CNT_W-1:0] htotal;
	logic [H_CNT_W-1:0] hvis;
	logic h_last;
	logic v_last;
	logic visible;
	logic row_load;

	assign htotal = stn_x2(cfg_pix.htot);
	assign hvis = stn_x8(cfg_pix.hact);
	assign h_last = (h_cnt_reg >= htotal - H_CNT_W'(1));
	assign v_last = (v_cnt_reg >= cfg_pix.vtot - V_W'(1));
	assign visible = (h_cnt_reg < hvis) && (v_cnt_reg < cfg_pix.vact);
	assign row_load = (v_cnt_reg < cfg_pix.vact) || cfg_pix.blank_row_load_enable;

	// x counts right, y counts down, from the top-left origin
	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			h_cnt_reg <= '0;
			v_cnt_reg <= '0;
		end else if (!scan_pix) begin
			h_cnt_reg <= '0;
			v_cnt_reg <= '0;
		end else if (h_last) begin
			h_cnt_reg <= '0;
			v_cnt_reg <= v_last ? '0 : v_cnt_reg + V_W'(1);
		end else begin
			h_cnt_reg <= h_cnt_reg + H_CNT_W'(1);
		end
	end

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) frame_start <= 1'b0;
		else frame_start <= scan_pix && at_top;
	end

	// ------------------------------------------------------------
	// load clock edges
	// ------------------------------------------------------------
	logic load_reg;
	logic hit_start;
	logic hit_end;

	assign hit_start = (h_cnt_reg == stn_x2(cfg_pix.load_start_pos));
	assign hit_end = (h_cnt_reg == stn_x2(cfg_pix.load_end_pos));

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			load_reg <= LOAD_IDLE_RST;
		end else if (!scan_pix) begin
			load_reg <= cfg_pix.load_clock_polarity;
		end else if (row_load && hit_start) begin
			load_reg <= ~cfg_pix.load_clock_polarity;
		end else if (row_load && hit_end) begin
			load_reg <= cfg_pix.load_clock_polarity;
		end
	end

	// ------------------------------------------------------------
	// pixel data and shift clock
	// ------------------------------------------------------------
	logic shift_reg;
	logic [7:0] pal_rd_idx;

	assign pix_take = scan_pix && visible;
	assign pal_rd_idx = (cfg_pix.depth == STN_D8) ? pix_in : {4'h0, pix_in[3:0]};

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			panel_data <= '0;
		end else if (!pix_take) begin
			panel_data <= '0;
		end else if (cfg_pix.color) begin
			panel_data <= pix_in;
		end else begin
			case (cfg_pix.depth)
				STN_D1: panel_data <= {4'h0, {MONO_DATA_W{pix_in[0]}}};
				STN_D2: panel_data <= {4'h0, pix_in[1:0], pix_in[1:0]};
				default: panel_data <= {4'h0, pix_in[3:0]};
			endcase
		end
	end

	// table read runs on the pixel clock; writes while scanning may show one stale pixel
	always_ff @(posedge pix_clk) begin
		color_rgb <= pal_mem[pal_rd_idx];
	end

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) shift_reg <= 1'b0;
		else if (pix_take) shift_reg <= ~shift_reg;
		else shift_reg <= 1'b0;
	end

	assign panel_data_upper_en = cfg_hold_reg.color;

	// ------------------------------------------------------------
	// pin assignment
	// ------------------------------------------------------------
	// plain mux so the external selects work while the pixel clock is stopped
	always_comb begin
		if (panel_pin_mode_select) begin
			pins.panel_shift_clock = ext_ctrl_chip_select_n;
			pins.line_load_clock = wide_mem_select_n;
			pins.panel_logic_power_out = gp_power_out_1;
			pins.panel_bias_power_out = gp_power_out_0;
		end else begin
			pins.panel_shift_clock = shift_reg;
			pins.line_load_clock = load_reg;
			pins.panel_logic_power_out = logic_on;
			pins.panel_bias_power_out = bias_on;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_h_wrap;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			scan_pix && h_cnt_reg == stn_x2(cfg_pix.htot) - H_CNT_W'(1) |=> h_cnt_reg == '0;
	endproperty
	a_h_wrap: assert property (p_h_wrap) else $error("x did not wrap at twice htot");

	property p_v_wrap;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			scan_pix && h_last && v_cnt_reg == cfg_pix.vtot - V_W'(1) |=> v_cnt_reg == '0;
	endproperty
	a_v_wrap: assert property (p_v_wrap) else $error("y did not wrap at vtot");

	property p_first_edge;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			scan_pix && row_load && hit_start && $stable(cfg_pix)
			|=> load_reg == ~$past(cfg_pix.load_clock_polarity);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first load edge wrong");

	property p_second_edge;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			scan_pix && row_load && hit_end && !hit_start
			|=> load_reg == $past(cfg_pix.load_clock_polarity);
	endproperty
	a_second_edge: assert property (p_second_edge) else $error("second load edge wrong");

	property p_blank_rows_quiet;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			scan_pix && $past(scan_pix) && v_cnt_reg >= cfg_pix.vact && !cfg_pix.blank_row_load_enable
			&& !at_top |=> $stable(load_reg);
	endproperty
	a_blank_rows_quiet: assert property (p_blank_rows_quiet) else $error("load edge in blank row");

	property p_take_in_view;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			h_cnt_reg >= stn_x8(cfg_pix.hact) || v_cnt_reg >= cfg_pix.vact |=> panel_data == '0;
	endproperty
	a_take_in_view: assert property (p_take_in_view) else $error("data driven in blank");
	property p_mono_nibble;
		@(posedge pix_clk) disable iff (!pix_rst_n)
			!cfg_pix.color ##1 !cfg_pix.color |-> panel_data[7:4] == 4'h0;
	endproperty
	a_mono_nibble: assert property (p_mono_nibble) else $error("upper nibble driven in mono");

	property p_pin_mode;
		@(posedge core_clk) disable iff (!nrst)
			panel_pin_mode_select |-> pins.panel_logic_power_out == gp_power_out_1
			&& pins.line_load_clock == wide_mem_select_n;
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("pin mode not applied");

	c_frame_wrap: cover property (@(posedge pix_clk) disable iff (!pix_rst_n) scan_pix && h_last && v_last);
	c_dummy_edge: cover property (@(posedge pix_clk) disable iff (!pix_rst_n)
		v_cnt_reg >= cfg_pix.vact && cfg_pix.blank_row_load_enable && hit_start && scan_pix);
	c_color_take: cover property (@(posedge pix_clk) disable iff (!pix_rst_n) pix_take && cfg_pix.color);
	c_cfg_swap: cover property (@(posedge core_clk) disable iff (!nrst) $fell(cfg_busy));
endmodule : stn_lcd_timing

// >>> bench/stn_panel_model.sv
`timescale 1ns/1ps
module stn_panel_model (
	// link side
	input wire logic pix_clk,
	input wire logic nrst,
	input wire stn_pkg::stn_pins_t pins,
	input wire logic [stn_pkg::DATA_W-1:0] panel_data,
	input wire logic pix_take,
	input wire logic frame_start,
	// per-frame tallies
	output int rise_n,
	output int fall_n,
	output int take_n,
	output int len_n,
	output int gap_n,
	output int frame_n,
	output logic idle_lvl,
	output logic [stn_pkg::DATA_W-1:0] last_data,
	output logic latch_bad
);
	import stn_pkg::*;
	int rc, fc, tc, lc, e1;
	logic ld_q;
	// ----
	// panel watching its pins
	// ----
	always_ff @(posedge pix_clk or negedge nrst) begin
		if (!nrst) begin
			{rc, fc, tc, lc, e1, rise_n, fall_n, take_n, len_n, gap_n, frame_n} <= '0;
			{ld_q, idle_lvl, last_data, latch_bad} <= '0;
		end else begin
			ld_q <= pins.line_load_clock;
			lc <= lc + 1;
			if (panel_data != '0) begin
				last_data <= panel_data;
			end
			// bias ahead of logic supply is what latches the panel up
			if (pins.panel_bias_power_out && !pins.panel_logic_power_out) begin
				latch_bad <= 1'b1;
			end
			if (frame_start) begin
				{rise_n, fall_n, take_n, len_n} <= {rc, fc, tc, lc};
				{rc, fc, e1} <= '0;
				// the pixel taken on this very edge opens the new frame
				tc <= pix_take ? 1 : 0;
				lc <= 1;
				idle_lvl <= pins.line_load_clock;
				frame_n <= frame_n + 1;
			end else begin
				if (pins.line_load_clock != ld_q) begin
					if (pins.line_load_clock) begin
						rc <= rc + 1;
					end else begin
						fc <= fc + 1;
					end
					if (rc + fc == 0) begin
						e1 <= lc;
					end
					if (rc + fc == 1) begin
						gap_n <= lc - e1;
					end
				end
				if (pix_take) begin
					tc <= tc + 1;
				end
			end
		end
	end
endmodule : stn_panel_model

// >>> bench/stn_lcd_timing_tb_top.sv
`timescale 1ns/1ps
module stn_lcd_timing_tb_top;
	import stn_pkg::*;
	localparam int STEP = 8;
	logic core_clk = 1'b0;
	logic pix_clk = 1'b0;
	logic nrst = 1'b0;
	stn_cfg_t cfg_in = CFG_RST;
	logic panel_enable = 1'b0;
	logic panel_pin_mode_select = 1'b0;
	logic pal_we = 1'b0;
	logic [7:0] pal_idx = 8'h00;
	logic [PAL_W-1:0] pal_wdata = '0;
	logic [DATA_W-1:0] pix_in = 8'h00;
	logic [3:0] ext_in = 4'h0;
	logic cfg_busy, panel_powered, pix_take, panel_data_upper_en, frame_start, idle_lvl, latch_bad;
	stn_pins_t pins;
	logic [DATA_W-1:0] panel_data, last_data;
	logic [PAL_W-1:0] color_rgb;
	int rise_n, fall_n, take_n, len_n, gap_n, frame_n;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// ----
	// clocks and timeout
	// ----
	always #2.5 core_clk = ~core_clk;
	initial begin
		#7;
		forever #32 pix_clk = ~pix_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			$display("BAD timeout expected finish seen hang");
			print_verdict();
		end
	end
	// ----
	// design and panel
	// ----
	stn_lcd_timing #(.PWR_STEP_CYC(STEP)) i_dut (.core_clk(core_clk), .nrst(nrst), .pix_clk(pix_clk),
		.cfg_in(cfg_in), .panel_enable(panel_enable), .panel_pin_mode_select(panel_pin_mode_select),
		.cfg_busy(cfg_busy), .panel_powered(panel_powered), .pal_we(pal_we), .pal_idx(pal_idx),
		.pal_wdata(pal_wdata), .pix_in(pix_in), .pix_take(pix_take), .ext_ctrl_chip_select_n(ext_in[3]),
		.wide_mem_select_n(ext_in[2]), .gp_power_out_1(ext_in[1]), .gp_power_out_0(ext_in[0]), .pins(pins),
		.panel_data(panel_data), .panel_data_upper_en(panel_data_upper_en), .color_rgb(color_rgb),
		.frame_start(frame_start));
	stn_panel_model i_panel (.pix_clk(pix_clk), .nrst(nrst), .pins(pins), .panel_data(panel_data),
		.pix_take(pix_take), .frame_start(frame_start), .rise_n(rise_n), .fall_n(fall_n), .take_n(take_n),
		.len_n(len_n), .gap_n(gap_n), .frame_n(frame_n), .idle_lvl(idle_lvl), .last_data(last_data),
		.latch_bad(latch_bad));
	// ----
	// shared tasks
	// ----
	task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check_val
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict
	// small panel: 20 by 6 box, 8 by 4 visible, load edges at x 10 and 16
	function automatic stn_cfg_t mk(input logic pol, input logic blank, input logic col, input stn_depth_t d);
		return '{htot: 8'h0A, hact: 6'h01, vtot: 9'h006, vact: 9'h004, load_start_pos: 8'h05,
			load_end_pos: 8'h08, load_clock_polarity: pol, blank_row_load_enable: blank, color: col, depth: d};
	endfunction : mk
	task automatic wait_frames(input int k);
		int f0 = frame_n;
		int n = 0;
		while (frame_n < f0 + k && n < 8000) begin
			@(negedge core_clk);
			n++;
		end
		check_val("frames seen", frame_n >= f0 + k, 1);
	endtask : wait_frames
	task automatic apply(input stn_cfg_t c, input logic [7:0] px, input int nfr);
		int n = 0;
		@(posedge core_clk);
		cfg_in <= c;
		pix_in <= px;
		repeat (2) @(posedge core_clk);
		check_val("cfg_busy up", cfg_busy, 1'b1);
		while (cfg_busy !== 1'b0 && n < 5000) begin
			@(negedge core_clk);
			n++;
		end
		check_val("cfg_busy down", cfg_busy, 1'b0);
		if (nfr > 0) begin
			wait_frames(nfr);
		end
	endtask : apply
	task automatic wait_pin(input int bit_no, input logic lvl, output int n);
		n = 0;
		while (pins[bit_no] !== lvl && n < 40) begin
			@(negedge core_clk);
			n++;
		end
	endtask : wait_pin
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		@(negedge core_clk);
		check_val("reset outputs", {pins, cfg_busy, panel_powered, pix_take, frame_start, panel_data}, '0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_power_up();
		int n;
		apply(mk(1'b0, 1'b0, 1'b0, STN_D4), 8'hA5, 0);
		@(posedge core_clk);
		panel_enable <= 1'b1;
		wait_pin(1, 1'b1, n);
		check_val("logic on", pins.panel_logic_power_out, 1'b1);
		check_val("bias waits", pins.panel_bias_power_out, 1'b0);
		wait_pin(0, 1'b1, n);
		check_val("bias step", n >= STEP && n <= STEP + 2, 1);
		@(negedge core_clk);
		check_val("powered", panel_powered, 1'b1);
		$display("test power up done");
	endtask : t_power_up
	task automatic t_modes();
		stn_depth_t dep[5] = '{STN_D1, STN_D2, STN_D4, STN_D4, STN_D8};
		logic [7:0] px[5] = '{8'hA5, 8'hA6, 8'hA5, 8'hA5, 8'hA5};
		logic [7:0] dx[5] = '{8'h0F, 8'h0A, 8'h05, 8'hA5, 8'hA5};
		stn_cfg_t c;
		@(posedge core_clk);
		pal_we <= 1'b1;
		pal_idx <= 8'h05;
		pal_wdata <= 18'h0F0F0;
		@(posedge core_clk);
		pal_idx <= 8'hA5;
		pal_wdata <= 18'h2A5C3;
		@(posedge core_clk);
		pal_we <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			c = mk(i[0], i[1], i >= 3, dep[i]);
			apply(c, px[i], 3);
			check_val("frame len", len_n, 2 * c.htot * c.vtot);
			check_val("pixels", take_n, 8 * c.hact * c.vact);
			check_val("load rises", rise_n, c.blank_row_load_enable ? c.vtot : c.vact);
			check_val("load falls", fall_n, c.blank_row_load_enable ? c.vtot : c.vact);
			check_val("load idle", idle_lvl, c.load_clock_polarity);
			check_val("edge gap", gap_n, 2 * (c.load_end_pos - c.load_start_pos));
			check_val("data", last_data, dx[i]);
			check_val("upper nibble", panel_data_upper_en, c.color);
			if (c.color) begin
				check_val("color", color_rgb, i == 3 ? 18'h0F0F0 : 18'h2A5C3);
			end
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_power_down();
		int n;
		@(posedge core_clk);
		panel_enable <= 1'b0;
		wait_pin(0, 1'b0, n);
		check_val("bias first", pins.panel_logic_power_out, 1'b1);
		wait_pin(1, 1'b0, n);
		check_val("logic off step", n >= STEP && n <= STEP + 3, 1);
		check_val("unpowered", panel_powered, 1'b0);
		check_val("latch order", latch_bad, 1'b0);
		$display("test power down done");
	endtask : t_power_down
	task automatic t_pin_mode();
		logic [3:0] pat[2] = '{4'hA, 4'h5};
		@(posedge core_clk);
		panel_pin_mode_select <= 1'b1;
		panel_enable <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			ext_in <= pat[i];
			repeat (STEP + 4) @(negedge core_clk);
			check_val("pin route", pins, pat[i]);
			check_val("no power", panel_powered, 1'b0);
		end
		@(posedge core_clk);
		panel_pin_mode_select <= 1'b0;
		panel_enable <= 1'b0;
		$display("test pin mode done");
	endtask : t_pin_mode
	// ----
	// main sequence
	// ----
	initial begin
		// held over several link clock edges so both domains see reset
		repeat (40) @(posedge core_clk);
		t_reset();
		@(posedge core_clk);
		nrst <= 1'b1;
		t_power_up();
		t_modes();
		t_power_down();
		t_pin_mode();
		print_verdict();
	end
endmodule : stn_lcd_timing_tb_top
